// file: include/mspc_pkg.sv
// Package: register map, field positions and carrier types for step/phase control
package mspc_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [3:0] ADDR_STEP   = 4'h0;
  localparam logic [3:0] ADDR_EVENT  = 4'h1;
  localparam logic [3:0] ADDR_PHASE  = 4'h2;
  localparam logic [3:0] ADDR_CTRL   = 4'h3;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [7:0] RESET_BYTE  = 8'h00;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int STEP_ZC_EDGE   = 6;
  localparam int STEP_HW_DEMAG  = 5;
  localparam int STEP_SIM_DEMAG = 4;
  localparam int STEP_OCV       = 3;
  localparam int STEP_OS_CD     = 2;
  localparam int STEP_OS_DZ     = 1;
  localparam int STEP_OS_ZC     = 0;
  localparam int EVT_FLAG       = 7;
  localparam int EVT_HZ_DIR     = 6;
  localparam int EVT_SZ         = 5;
  localparam int EVT_SC         = 4;
  localparam int EVT_FAST_Z_SAMPLING       = 3;
  localparam int CTRL_MOE       = 0;
  localparam int CTRL_SR        = 1;
  localparam int CTRL_DAC       = 2;
  localparam int CTRL_SWA       = 3;
  localparam int CTRL_CURRENT_LIMIT_IRQ_MASK      = 4;
  localparam int CTRL_TES_LO    = 5;
  localparam logic [7:0] STEP_PRELOAD_MASK  = 8'h74;
  localparam logic [7:0] STEP_WRITE_MASK    = 8'h7F;
  localparam logic [7:0] EVENT_WRITE_MASK   = 8'h3F;
  localparam logic [2:0] VR_EXTERNAL        = 3'h7;
  localparam logic [1:0] IS_ENCODER         = 2'h3;
  localparam logic [1:0] TES_POSITION       = 2'h0;

  // ----------------------------------------
  // Carrier types
  // ----------------------------------------
  typedef enum logic [1:0] {
    MSPC_SEG_CD = 2'b00,
    MSPC_SEG_DZ = 2'b01,
    MSPC_SEG_ZC = 2'b10
  } mspc_seg_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } mspc_bus_req_t;

  typedef struct packed {
    logic c_evt;
    logic d_evt;
    logic z_evt;
    logic overflow;
    logic speed_err;
    logic cur_limit;
  } mspc_events_t;

  typedef struct packed {
    logic [7:0] step_active;
    logic [7:0] step_pre;
    logic [7:0] evt;
    logic [7:0] phase_active;
    logic [7:0] phase_pre;
    logic [7:0] ctrl;
    logic       cl_flag;
    mspc_seg_t  seg;
    logic       qa_d;
    logic       a_d;
    logic       encoder_dir;
    logic [7:0] rdata;
    logic [1:0] sync_a;
    logic [1:0] sync_b;
    logic [1:0] sync_cmp;
  } mspc_state_t;

endpackage : mspc_pkg

// file: design/mspc_core.sv
// Commutation step, event flag and phase state control
//
// Notes on behaviour
// - Bit 6 picks zero-crossing comparator edge
// - Bit 5 enables hardware demagnetisation events
// - Bit 4 enables simulated demagnetisation events
// - Masked current limit: interrupt, PWM off or trip
// - Sensorless: bits 2:0 choose side per interval
// - Preload bits move at C; others immediate
// - Direct access phase write makes C event
// - Whole-byte writes; preload bits reset otherwise
// - Position mode: overflow flag sticky, no interrupt
// - Speed mode: bit 7 shows speed error
// - Position mode: bit 6 selects hardware Z
// - Speed mode: bit 6 shows quadrature lead
// - Bit 5 requests simulated zero crossing
// - Auto mode: bit 4 chooses commutation source
// - Fast Z sampling: continuous, else off-time end
// - Fast Z sampling forces minimum off time zero
// - Threshold select; all ones picks external pin
// - Input select routes channel or encoder mode
// - Channel on bits apply at C or immediately
// - Direct access drives outputs from phase write
//
// Strobed register access and the placing of the registers were decided locally.
module mspc_core (
  input  wire logic                 sys_clk,
  input  wire logic                 sys_rst,
  input  wire mspc_pkg::mspc_bus_req_t bus_req,
  output logic [7:0]                rdata,
  input  wire mspc_pkg::mspc_events_t  events,
  input  wire logic                 pos_input_a,
  input  wire logic                 pos_input_b,
  input  wire logic                 comparator_out,
  input  wire logic                 pwm_off_time_end,
  output logic [5:0]                motor_outputs,
  output logic                      pwm_on_low,
  output logic                      pwm_kill,
  output logic                      current_limit_irq,
  output logic                      output_enable_master,
  output logic [1:0]                comp_channel_sel,
  output logic                      encoder_mode,
  output logic [2:0]                bemf_threshold_sel,
  output logic                      ext_threshold_used,
  output logic                      zc_edge_pick,
  output logic                      zc_detect,
  output logic                      demag_event,
  output logic                      z_sample_enable,
  output logic                      min_off_time_zero,
  output logic                      commutate
);

  mspc_pkg::mspc_state_t s_reg;
  mspc_pkg::mspc_state_t s_next;

  logic       wr_step;
  logic       wr_evt;
  logic       wr_phase;
  logic       wr_ctrl;
  logic       c_evt;
  logic       pos_mode;
  logic       dac;
  logic       cmp_q;
  logic       cmp_edge;
  logic       side_sel;
  logic [7:0] step_w;

  // ----------------------------------------
  // Decode and event sources
  // ----------------------------------------
  assign wr_step  = bus_req.wr && (bus_req.addr == mspc_pkg::ADDR_STEP);
  assign wr_evt   = bus_req.wr && (bus_req.addr == mspc_pkg::ADDR_EVENT);
  assign wr_phase = bus_req.wr && (bus_req.addr == mspc_pkg::ADDR_PHASE);
  assign wr_ctrl  = bus_req.wr && (bus_req.addr == mspc_pkg::ADDR_CTRL);
  assign dac      = s_reg.ctrl[mspc_pkg::CTRL_DAC];
  assign pos_mode = (s_reg.ctrl[mspc_pkg::CTRL_TES_LO +: 2] == mspc_pkg::TES_POSITION);
  assign step_w   = bus_req.wdata & mspc_pkg::STEP_WRITE_MASK;

  // Commutation: hardware or simulated in auto mode, forced in direct access
  always_comb
  begin
    if (s_reg.ctrl[mspc_pkg::CTRL_SWA] && s_reg.evt[mspc_pkg::EVT_SC])
      c_evt = 1'b1;
    else
      c_evt = events.c_evt;
    if (dac && wr_phase)
      c_evt = 1'b1;
  end

  // Comparator edge after two-stage synchroniser
  assign cmp_q    = s_reg.sync_cmp[1];
  assign cmp_edge = s_reg.step_active[mspc_pkg::STEP_ZC_EDGE] ?
                    (cmp_q && !s_reg.qa_d) : (!cmp_q && s_reg.qa_d);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    s_next = s_reg;
    s_next.sync_a   = {s_reg.sync_a[0], pos_input_a};
    s_next.sync_b   = {s_reg.sync_b[0], pos_input_b};
    s_next.sync_cmp = {s_reg.sync_cmp[0], comparator_out};
    s_next.qa_d     = cmp_q;
    s_next.a_d      = s_reg.sync_a[1];
    // Quadrature lead taken on each change of synchronised A
    if (s_reg.sync_a[1] != s_reg.a_d)
      s_next.encoder_dir = s_reg.a_d ~^ s_reg.sync_b[1];

    // Step register: preload bits to shadow, others direct
    if (wr_step)
    begin
      s_next.step_pre = step_w;
      s_next.step_active = (s_reg.step_active & mspc_pkg::STEP_PRELOAD_MASK)
                         | (step_w & ~mspc_pkg::STEP_PRELOAD_MASK);
    end
    if (wr_phase)
      s_next.phase_pre = bus_req.wdata;
    if (c_evt)
    begin
      s_next.step_active = (s_next.step_pre & mspc_pkg::STEP_PRELOAD_MASK)
                         | (s_next.step_active & ~mspc_pkg::STEP_PRELOAD_MASK);
      s_next.phase_active = s_next.phase_pre;
      s_next.seg = mspc_pkg::MSPC_SEG_CD;
    end
    else if (events.d_evt && s_reg.seg == mspc_pkg::MSPC_SEG_CD && !s_reg.ctrl[mspc_pkg::CTRL_SR])
      s_next.seg = mspc_pkg::MSPC_SEG_DZ;
    else if (events.z_evt || s_reg.evt[mspc_pkg::EVT_SZ])
      s_next.seg = mspc_pkg::MSPC_SEG_ZC;

    // Event control register
    if (wr_evt)
    begin
      s_next.evt = (bus_req.wdata & mspc_pkg::EVENT_WRITE_MASK)
                 | (s_reg.evt & ~mspc_pkg::EVENT_WRITE_MASK & ~(8'h01 << mspc_pkg::EVT_FLAG));
      if (pos_mode)
        s_next.evt[mspc_pkg::EVT_HZ_DIR] = bus_req.wdata[mspc_pkg::EVT_HZ_DIR];
      if (bus_req.wdata[mspc_pkg::EVT_FLAG])
        s_next.evt[mspc_pkg::EVT_FLAG] = s_reg.evt[mspc_pkg::EVT_FLAG];
    end
    if (pos_mode ? events.overflow : events.speed_err)
      s_next.evt[mspc_pkg::EVT_FLAG] = 1'b1;

    // Control and current limit
    if (wr_ctrl)
      s_next.ctrl = bus_req.wdata;
    s_next.cl_flag = events.cur_limit;
    if (events.cur_limit && s_reg.ctrl[mspc_pkg::CTRL_CURRENT_LIMIT_IRQ_MASK]
        && s_reg.step_active[mspc_pkg::STEP_OCV])
      s_next.ctrl[mspc_pkg::CTRL_MOE] = 1'b0;

    // Read data, one cycle later
    s_next.rdata = mspc_pkg::RESET_BYTE;
    if (bus_req.rd)
    begin
      unique case (bus_req.addr)
        mspc_pkg::ADDR_STEP:   s_next.rdata = s_reg.step_pre;
        mspc_pkg::ADDR_EVENT:
        begin
          s_next.rdata = s_reg.evt;
          if (!pos_mode)
            s_next.rdata[mspc_pkg::EVT_HZ_DIR] = s_reg.encoder_dir;
        end
        mspc_pkg::ADDR_PHASE:  s_next.rdata = s_reg.phase_pre;
        mspc_pkg::ADDR_CTRL:   s_next.rdata = s_reg.ctrl;
        mspc_pkg::ADDR_STATUS: s_next.rdata = {5'h00, s_reg.seg, s_reg.cl_flag};
        default:               s_next.rdata = mspc_pkg::RESET_BYTE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  always_comb
  begin
    if (dac)
      side_sel = s_reg.step_active[mspc_pkg::STEP_OS_ZC];
    else if (s_reg.ctrl[mspc_pkg::CTRL_SR])
      side_sel = (s_reg.seg == mspc_pkg::MSPC_SEG_ZC) ?
                 s_reg.step_active[mspc_pkg::STEP_OS_ZC] :
                 s_reg.step_active[mspc_pkg::STEP_OS_CD];
    else
    begin
      unique case (s_reg.seg)
        mspc_pkg::MSPC_SEG_CD: side_sel = s_reg.step_active[mspc_pkg::STEP_OS_CD];
        mspc_pkg::MSPC_SEG_DZ: side_sel = s_reg.step_active[mspc_pkg::STEP_OS_DZ];
        mspc_pkg::MSPC_SEG_ZC: side_sel = s_reg.step_active[mspc_pkg::STEP_OS_ZC];
        default:               side_sel = s_reg.step_active[mspc_pkg::STEP_OS_ZC];
      endcase
    end
  end

  assign rdata                = s_reg.rdata;
  assign pwm_on_low           = side_sel;
  assign output_enable_master = s_reg.ctrl[mspc_pkg::CTRL_MOE];
  assign motor_outputs        = output_enable_master ? s_reg.phase_active[5:0] : 6'h00;
  assign pwm_kill             = s_reg.cl_flag;
  assign current_limit_irq    = s_reg.cl_flag && s_reg.ctrl[mspc_pkg::CTRL_CURRENT_LIMIT_IRQ_MASK];
  assign comp_channel_sel     = s_reg.phase_active[7:6];
  assign encoder_mode         = (s_reg.phase_active[7:6] == mspc_pkg::IS_ENCODER);
  assign bemf_threshold_sel   = s_reg.evt[2:0];
  assign ext_threshold_used   = (s_reg.evt[2:0] == mspc_pkg::VR_EXTERNAL);
  assign zc_edge_pick         = s_reg.step_active[mspc_pkg::STEP_ZC_EDGE];
  assign zc_detect            = cmp_edge && pos_mode && s_reg.evt[mspc_pkg::EVT_HZ_DIR]
                                && (s_reg.evt[mspc_pkg::EVT_FAST_Z_SAMPLING] || pwm_off_time_end);
  assign demag_event          = (events.d_evt && s_reg.step_active[mspc_pkg::STEP_HW_DEMAG])
                                || (s_reg.evt[mspc_pkg::EVT_SZ]
                                && s_reg.step_active[mspc_pkg::STEP_SIM_DEMAG]);
  assign z_sample_enable      = s_reg.evt[mspc_pkg::EVT_FAST_Z_SAMPLING] || pwm_off_time_end;
  assign min_off_time_zero    = s_reg.evt[mspc_pkg::EVT_FAST_Z_SAMPLING];
  assign commutate            = c_evt;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_dac_c;
    @(posedge sys_clk) disable iff (sys_rst)
      (dac && wr_phase) |-> commutate;
  endproperty
  a_dac_c: assert property (p_dac_c) else $error("no C on direct write");

  property p_phase_load;
    @(posedge sys_clk) disable iff (sys_rst)
      (c_evt && wr_phase) |=> (s_reg.phase_active == $past(bus_req.wdata));
  endproperty
  a_phase_load: assert property (p_phase_load) else $error("phase not loaded");

  property p_flag_sticky;
    @(posedge sys_clk) disable iff (sys_rst)
      (pos_mode && events.overflow && !wr_ctrl) |=> s_reg.evt[mspc_pkg::EVT_FLAG];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("overflow flag lost");

  property p_trip;
    @(posedge sys_clk) disable iff (sys_rst)
      (events.cur_limit && s_reg.ctrl[mspc_pkg::CTRL_CURRENT_LIMIT_IRQ_MASK]
       && s_reg.step_active[mspc_pkg::STEP_OCV] && !wr_ctrl) |=> !output_enable_master;
  endproperty
  a_trip: assert property (p_trip) else $error("trip did not clear enable");

  property p_no_irq;
    @(posedge sys_clk) disable iff (sys_rst)
      !s_reg.ctrl[mspc_pkg::CTRL_CURRENT_LIMIT_IRQ_MASK] |-> !current_limit_irq;
  endproperty
  a_no_irq: assert property (p_no_irq) else $error("irq while masked");

  property p_preload_hold;
    @(posedge sys_clk) disable iff (sys_rst)
      (wr_step && !c_evt) |=> ((s_reg.step_active & mspc_pkg::STEP_PRELOAD_MASK)
        == ($past(s_reg.step_active) & mspc_pkg::STEP_PRELOAD_MASK));
  endproperty
  a_preload_hold: assert property (p_preload_hold) else $error("preload moved early");

  property p_rsvd;
    @(posedge sys_clk) disable iff (sys_rst)
      wr_step |=> !s_reg.step_pre[7];
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit set");

  property p_offtime;
    @(posedge sys_clk) disable iff (sys_rst)
      (wr_evt && bus_req.wdata[mspc_pkg::EVT_FAST_Z_SAMPLING]) |=> min_off_time_zero;
  endproperty
  a_offtime: assert property (p_offtime) else $error("off time not forced");

  property p_zc_edge;
    @(posedge sys_clk) disable iff (sys_rst)
      cmp_edge |-> (cmp_q == s_reg.step_active[mspc_pkg::STEP_ZC_EDGE]);
  endproperty
  a_zc_edge: assert property (p_zc_edge) else $error("wrong zero-crossing edge");

  property p_hw_demag;
    @(posedge sys_clk) disable iff (sys_rst)
      (events.d_evt && s_reg.step_active[mspc_pkg::STEP_HW_DEMAG]) |-> demag_event;
  endproperty
  a_hw_demag: assert property (p_hw_demag) else $error("hw demag lost");

  property p_demag_off;
    @(posedge sys_clk) disable iff (sys_rst)
      (!s_reg.step_active[mspc_pkg::STEP_HW_DEMAG]
       && !s_reg.step_active[mspc_pkg::STEP_SIM_DEMAG]) |-> !demag_event;
  endproperty
  a_demag_off: assert property (p_demag_off) else $error("demag while disabled");

  property p_sim_demag;
    @(posedge sys_clk) disable iff (sys_rst)
      (s_reg.evt[mspc_pkg::EVT_SZ] && s_reg.step_active[mspc_pkg::STEP_SIM_DEMAG]) |-> demag_event;
  endproperty
  a_sim_demag: assert property (p_sim_demag) else $error("sim demag lost");

  property p_irq;
    @(posedge sys_clk) disable iff (sys_rst)
      (events.cur_limit && s_reg.ctrl[mspc_pkg::CTRL_CURRENT_LIMIT_IRQ_MASK] && !wr_ctrl) |=> current_limit_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("no current limit irq");

  property p_kill;
    @(posedge sys_clk) disable iff (sys_rst)
      events.cur_limit |=> pwm_kill;
  endproperty
  a_kill: assert property (p_kill) else $error("pwm not killed");

  property p_seg_c;
    @(posedge sys_clk) disable iff (sys_rst)
      c_evt |=> (s_reg.seg == mspc_pkg::MSPC_SEG_CD);
  endproperty
  a_seg_c: assert property (p_seg_c) else $error("interval not restarted");

  property p_sensor_side;
    @(posedge sys_clk) disable iff (sys_rst)
      (!dac && s_reg.ctrl[mspc_pkg::CTRL_SR] && s_reg.seg == mspc_pkg::MSPC_SEG_ZC)
        |-> (pwm_on_low == s_reg.step_active[mspc_pkg::STEP_OS_ZC]);
  endproperty
  a_sensor_side: assert property (p_sensor_side) else $error("sensor side wrong");

  property p_dac_side;
    @(posedge sys_clk) disable iff (sys_rst)
      dac |-> (pwm_on_low == s_reg.step_active[mspc_pkg::STEP_OS_ZC]);
  endproperty
  a_dac_side: assert property (p_dac_side) else $error("direct side wrong");

  property p_speed_flag;
    @(posedge sys_clk) disable iff (sys_rst)
      (!pos_mode && events.speed_err) |=> s_reg.evt[mspc_pkg::EVT_FLAG];
  endproperty
  a_speed_flag: assert property (p_speed_flag) else $error("speed error lost");

  property p_hz_write;
    @(posedge sys_clk) disable iff (sys_rst)
      (wr_evt && pos_mode) |=> (s_reg.evt[mspc_pkg::EVT_HZ_DIR] == $past(bus_req.wdata[6]));
  endproperty
  a_hz_write: assert property (p_hz_write) else $error("hw Z select not written");

  property p_sim_c;
    @(posedge sys_clk) disable iff (sys_rst)
      (s_reg.ctrl[mspc_pkg::CTRL_SWA] && s_reg.evt[mspc_pkg::EVT_SC]) |-> commutate;
  endproperty
  a_sim_c: assert property (p_sim_c) else $error("no simulated C");

  property p_zsample;
    @(posedge sys_clk) disable iff (sys_rst)
      !s_reg.evt[mspc_pkg::EVT_FAST_Z_SAMPLING] |-> (z_sample_enable == pwm_off_time_end);
  endproperty
  a_zsample: assert property (p_zsample) else $error("Z sampled outside off end");

  property p_outs_off;
    @(posedge sys_clk) disable iff (sys_rst)
      !output_enable_master |-> (motor_outputs == 6'h00);
  endproperty
  a_outs_off: assert property (p_outs_off) else $error("outputs on while disabled");

  property p_ext;
    @(posedge sys_clk) disable iff (sys_rst)
      ext_threshold_used |-> (bemf_threshold_sel == mspc_pkg::VR_EXTERNAL);
  endproperty
  a_ext: assert property (p_ext) else $error("threshold decode wrong");

endmodule : mspc_core

// file: verif/mspc_partner.sv
// Partner model: rotor position inputs driven as an encoder in quadrature
module mspc_partner (
  input  wire logic sys_clk,
  input  wire logic run,
  input  wire logic lead_a,
  output logic      pos_input_a,
  output logic      pos_input_b,
  output logic      comparator_out
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0] cnt_reg = 4'h0;

  // ----------------------------------------
  // Quadrature sequence, one quarter per four clocks
  // ----------------------------------------
  always @(posedge sys_clk)
  begin
    if (run)
    begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end

  // Lead of A over B flips with lead_a
  assign pos_input_a    = cnt_reg[3];
  assign pos_input_b    = cnt_reg[3] ^ cnt_reg[2] ^ lead_a;
  assign comparator_out = cnt_reg[2];
endmodule : mspc_partner

// file: verif/mspc_core_tb_top.sv
// Testbench: register access, preload, direct access and protection checks
module mspc_core_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [7:0] phase;
    logic [5:0] outs;
    logic [1:0] sel;
    logic       enc;
  } mspc_row_t;

  logic                    sys_clk, sys_rst, run, lead_a, last_com;
  mspc_pkg::mspc_bus_req_t bus_req;
  mspc_pkg::mspc_events_t  events;
  logic                    pwm_off_time_end, pos_input_a, pos_input_b, comparator_out;
  logic [7:0]              rdata;
  logic [5:0]              motor_outputs;
  logic [2:0]              bemf_threshold_sel;
  logic [1:0]              comp_channel_sel;
  logic                    pwm_on_low, pwm_kill, current_limit_irq, output_enable_master;
  logic                    encoder_mode, ext_threshold_used, zc_edge_pick, zc_detect;
  logic                    demag_event, z_sample_enable, min_off_time_zero, commutate;
  int                      n_errors = 0;
  int                      num_checks = 0;
  int                      n_zc = 0;
  mspc_row_t               rows [4] = '{'{8'h3F, 6'h3F, 2'h0, 1'b0},
                                        '{8'h55, 6'h15, 2'h1, 1'b0},
                                        '{8'hAA, 6'h2A, 2'h2, 1'b0},
                                        '{8'hC7, 6'h07, 2'h3, 1'b1}};

  mspc_core u_mspc_core (.sys_clk, .sys_rst, .bus_req, .rdata, .events, .pos_input_a,
    .pos_input_b, .comparator_out, .pwm_off_time_end, .motor_outputs, .pwm_on_low,
    .pwm_kill, .current_limit_irq, .output_enable_master, .comp_channel_sel,
    .encoder_mode, .bemf_threshold_sel, .ext_threshold_used, .zc_edge_pick, .zc_detect,
    .demag_event, .z_sample_enable, .min_off_time_zero, .commutate);

  mspc_partner u_mspc_partner (.sys_clk, .run, .lead_a, .pos_input_a, .pos_input_b,
    .comparator_out);

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus_req <= '{a, d, 1'b1, 1'b0};
    #1 last_com = commutate;
    @(posedge sys_clk);
    bus_req <= '0;
    tick(2);
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
    @(posedge sys_clk);
    bus_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge sys_clk);
    bus_req <= '0;
    #1 chk(rdata & m, e);
  endtask : rd

  task automatic ev(input logic [5:0] m);
    @(posedge sys_clk);
    events <= m;
    @(posedge sys_clk);
    events <= '0;
    tick(1);
  endtask : ev

  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
    begin
      $display("Simulation passed");
    end
    else
    begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict

  // ----------------------------------------
  // Clock, watchdog and test sequence
  // ----------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  initial
  begin
    repeat (4000) @(posedge sys_clk);
    n_errors++;
    give_verdict();
  end

  initial
  begin
    sys_rst = 1'b1;
    bus_req = '0;
    events = '0;
    pwm_off_time_end = 1'b0;
    run = 1'b0;
    lead_a = 1'b1;
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
    wr(mspc_pkg::ADDR_CTRL, 8'h05);
    wr(mspc_pkg::ADDR_STEP, 8'h01);
    foreach (rows[i])
    begin
      wr(mspc_pkg::ADDR_PHASE, rows[i].phase);
      chk({7'h0, last_com}, 8'h01);
      chk({2'h0, motor_outputs}, {2'h0, rows[i].outs});
      chk({6'h0, comp_channel_sel}, {6'h0, rows[i].sel});
      chk({7'h0, encoder_mode}, {7'h0, rows[i].enc});
      chk({7'h0, pwm_on_low}, 8'h01);
      $display("Row %0d done", i);
    end
    sys_rst <= 1'b1;
    tick(2);
    sys_rst <= 1'b0;
    chk({2'h0, motor_outputs}, 8'h00);
    for (int a = 0; a < 4; a++)
    begin
      rd(a[3:0], 8'h00);
    end
    rd(4'hF, 8'h00);
    wr(mspc_pkg::ADDR_STEP, 8'hFF);
    rd(mspc_pkg::ADDR_STEP, 8'h7F);
    $display("Reset and step byte done");
    wr(mspc_pkg::ADDR_CTRL, 8'h01);
    wr(mspc_pkg::ADDR_EVENT, 8'h40);
    wr(mspc_pkg::ADDR_STEP, 8'h45);
    wr(mspc_pkg::ADDR_PHASE, 8'h3F);
    chk({7'h0, zc_edge_pick}, 8'h00);
    chk({2'h0, motor_outputs}, 8'h00);
    ev(6'h20);
    tick(1);
    chk({7'h0, zc_edge_pick}, 8'h01);
    chk({2'h0, motor_outputs}, 8'h3F);
    chk({7'h0, pwm_on_low}, 8'h01);
    ev(6'h10);
    chk({7'h0, pwm_on_low}, 8'h00);
    ev(6'h08);
    chk({7'h0, pwm_on_low}, 8'h01);
    wr(mspc_pkg::ADDR_STEP, 8'h44);
    chk({7'h0, pwm_on_low}, 8'h00);
    $display("Preload and interval side done");
    for (int v = 0; v < 8; v++)
    begin
      wr(mspc_pkg::ADDR_EVENT, {5'h09, v[2:0]});
      chk({5'h0, bemf_threshold_sel}, {5'h0, v[2:0]});
      chk({7'h0, ext_threshold_used}, {7'h0, v == 7});
      chk({7'h0, min_off_time_zero}, 8'h01);
    end
    ev(6'h04);
    rd(mspc_pkg::ADDR_EVENT, 8'h80, 8'h80);
    wr(mspc_pkg::ADDR_EVENT, 8'h40);
    rd(mspc_pkg::ADDR_EVENT, 8'h40, 8'hC0);
    $display("Threshold and overflow done");
    for (int i = 0; i < 3; i++)
    begin
      wr(mspc_pkg::ADDR_CTRL, (i < 2) ? 8'h11 : 8'h01);
      wr(mspc_pkg::ADDR_STEP, (i == 1) ? 8'h00 : 8'h08);
      events <= 6'h01;
      tick(2);
      chk({7'h0, pwm_kill}, 8'h01);
      chk({7'h0, current_limit_irq}, {7'h0, i < 2});
      events <= '0;
      tick(2);
      chk({7'h0, output_enable_master}, {7'h0, i != 0});
    end
    $display("Current limit done");
    wr(mspc_pkg::ADDR_STEP, 8'h71);
    wr(mspc_pkg::ADDR_CTRL, 8'h0B);
    wr(mspc_pkg::ADDR_EVENT, 8'h18);
    chk({7'h0, commutate}, 8'h01);
    chk({7'h0, pwm_on_low}, 8'h00);
    chk({7'h0, zc_edge_pick}, 8'h01);
    wr(mspc_pkg::ADDR_EVENT, 8'h68);
    chk({7'h0, commutate}, 8'h00);
    chk({7'h0, pwm_on_low}, 8'h01);
    chk({7'h0, demag_event}, 8'h01);
    chk({7'h0, z_sample_enable}, 8'h01);
    wr(mspc_pkg::ADDR_EVENT, 8'h48);
    chk({7'h0, demag_event}, 8'h00);
    @(posedge sys_clk);
    events <= 6'h10;
    #1 chk({7'h0, demag_event}, 8'h01);
    @(posedge sys_clk);
    events <= '0;
    run <= 1'b1;
    repeat (32)
    begin
      @(posedge sys_clk);
      #1 n_zc += zc_detect;
    end
    chk({4'h0, n_zc[3:0]}, 8'h04);
    wr(mspc_pkg::ADDR_EVENT, 8'h40);
    chk({7'h0, z_sample_enable}, 8'h00);
    @(posedge sys_clk);
    pwm_off_time_end <= 1'b1;
    #1 chk({7'h0, z_sample_enable}, 8'h01);
    @(posedge sys_clk);
    pwm_off_time_end <= 1'b0;
    $display("Sensor mode and simulated events done");
    wr(mspc_pkg::ADDR_CTRL, 8'h20);
    run <= 1'b1;
    tick(40);
    rd(mspc_pkg::ADDR_EVENT, 8'h40, 8'h40);
    lead_a <= 1'b0;
    tick(40);
    rd(mspc_pkg::ADDR_EVENT, 8'h00, 8'h40);
    ev(6'h02);
    rd(mspc_pkg::ADDR_EVENT, 8'h80, 8'h80);
    $display("Speed sensor mode done");
    give_verdict();
  end
endmodule : mspc_core_tb_top
